/* File: common/jtag_scan_cfg.svh */
`ifndef JTAG_SCAN_CFG_SVH
`define JTAG_SCAN_CFG_SVH

// ****************************************
// Instruction codes
// ****************************************
`define INSTR_EXTEST    4'h0
`define INSTR_WAKE      4'h1
`define INSTR_SAMPLE    4'h4
`define INSTR_INTERRUPT 4'h5
`define INSTR_BYPASS    4'hF
`define IR_CAPTURE_VAL  4'h1

// ****************************************
// Widths and timing
// ****************************************
`define IR_WIDTH        4
`define SYNC_STAGES     3
`define TDO_FIFO_DEPTH  2

`endif

/* File: common/jtag_scan_pkg.sv */
package jtag_scan_pkg;

    typedef enum logic [3:0] {
        TAP_RESET      = 4'b0000,
        TAP_IDLE       = 4'b0001,
        TAP_SEL_DR     = 4'b0010,
        TAP_CAPTURE_DR = 4'b0011,
        TAP_SHIFT_DR   = 4'b0100,
        TAP_EXIT1_DR   = 4'b0101,
        TAP_PAUSE_DR   = 4'b0110,
        TAP_EXIT2_DR   = 4'b0111,
        TAP_UPDATE_DR  = 4'b1000,
        TAP_SEL_IR     = 4'b1001,
        TAP_CAPTURE_IR = 4'b1010,
        TAP_SHIFT_IR   = 4'b1011,
        TAP_EXIT1_IR   = 4'b1100,
        TAP_PAUSE_IR   = 4'b1101,
        TAP_EXIT2_IR   = 4'b1110,
        TAP_UPDATE_IR  = 4'b1111
    } tap_state_e;

    typedef logic [3:0] instr_t;

endpackage

/* File: logic/tdo_fifo.sv */
`timescale 1ns/1ns
`include "jtag_scan_cfg.svh"

module tdo_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = `TDO_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PW-1:0]    wrPtr_reg, wrPtr_next;
    logic [PW-1:0]    rdPtr_reg, rdPtr_next;
    logic [PW:0]      count_reg, count_next;
    logic             doPush, doPop;

    assign inReady  = (count_reg != (PW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem_reg[rdPtr_reg];

    always_comb begin
        doPush = inValid && inReady;
        doPop  = outValid && outReady;
        mem_next   = mem_reg;
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (doPush) begin
            mem_next[wrPtr_reg] = inData;
            wrPtr_next = (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
        end
        if (doPop) begin
            rdPtr_next = (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
        end
        if (doPush && !doPop) begin
            count_next = count_reg + 1'b1;
        end else if (doPop && !doPush) begin
            count_next = count_reg - 1'b1;
        end
        if (flush) begin
            wrPtr_next = '0;
            rdPtr_next = '0;
            count_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
        mem_reg <= mem_next;
    end

endmodule

/* File: logic/jtag_boundary_scan.sv */
`timescale 1ns/1ns
`include "jtag_scan_cfg.svh"

module jtag_boundary_scan #(
    parameter int NUM_IN  = 8,
    parameter int NUM_OUT = 8
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Debug port pins
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic               trstN,
    output logic                    tdo,
    output logic                    tdoOe,
    // Board side of scanned pins
    input  wire logic [NUM_IN-1:0]  pinIn,
    input  wire logic               crystalInput,
    input  wire logic               busClockPin,
    output logic      [NUM_OUT-1:0] pinOut,
    output logic      [NUM_OUT-1:0] pinOe,
    // Core side of scanned pins
    output logic      [NUM_IN-1:0]  coreIn,
    input  wire logic [NUM_OUT-1:0] coreOut,
    input  wire logic [NUM_OUT-1:0] coreOe,
    // Power mode and commands to the core
    input  wire logic               standbyMode,
    output logic                    sleepWake,
    output logic                    debugInterrupt,
    output logic [`IR_WIDTH-1:0]    activeInstr
);

    // ****************************************
    // Chain layout
    // ****************************************
    // Inputs first (nearest TDO), then output data, then output enables.
    // Reset pins and debug port pins have no cells.
    localparam int NI = NUM_IN + 2;
    localparam int CL = NI + 2 * NUM_OUT;
    localparam int SW = NI + 4;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [SW-1:0] syncA_reg, syncB_reg, syncC_reg;
    logic [SW-1:0] filt_reg, filt_next;
    logic [SW-1:0] rawPins;
    logic          tckStable, tmsF, tdiF, trstNF;
    logic [NI-1:0] inF;
    logic          tckRise, tckFall;

    // Crystal and bus clock observed by the chain.
    assign rawPins = {trstN, tck, tms, tdi, busClockPin, crystalInput, pinIn};

    always_comb begin
        // A bit moves only once stages two and three agree
        filt_next = (syncB_reg & ~(syncB_reg ^ syncC_reg)) | (filt_reg & (syncB_reg ^ syncC_reg));
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
            syncC_reg <= '0;
            filt_reg  <= '0;
        end else begin
            syncA_reg <= rawPins;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
            filt_reg  <= filt_next;
        end
    end

    assign trstNF    = filt_reg[SW-1];
    assign tckStable = filt_reg[SW-2];
    assign tmsF      = filt_next[SW-3];
    assign tdiF      = filt_next[SW-4];
    assign inF       = filt_reg[NI-1:0];
    assign tckRise   = filt_next[SW-2] && !tckStable;
    assign tckFall   = !filt_next[SW-2] && tckStable;

    // ****************************************
    // Functions
    // ****************************************
    function automatic jtag_scan_pkg::tap_state_e tapStep(input jtag_scan_pkg::tap_state_e s, input logic m);
        case (s)
            jtag_scan_pkg::TAP_RESET:      tapStep = m ? jtag_scan_pkg::TAP_RESET    : jtag_scan_pkg::TAP_IDLE;
            jtag_scan_pkg::TAP_IDLE:       tapStep = m ? jtag_scan_pkg::TAP_SEL_DR   : jtag_scan_pkg::TAP_IDLE;
            jtag_scan_pkg::TAP_SEL_DR:     tapStep = m ? jtag_scan_pkg::TAP_SEL_IR   : jtag_scan_pkg::TAP_CAPTURE_DR;
            jtag_scan_pkg::TAP_CAPTURE_DR: tapStep = m ? jtag_scan_pkg::TAP_EXIT1_DR : jtag_scan_pkg::TAP_SHIFT_DR;
            jtag_scan_pkg::TAP_SHIFT_DR:   tapStep = m ? jtag_scan_pkg::TAP_EXIT1_DR : jtag_scan_pkg::TAP_SHIFT_DR;
            jtag_scan_pkg::TAP_EXIT1_DR:   tapStep = m ? jtag_scan_pkg::TAP_UPDATE_DR : jtag_scan_pkg::TAP_PAUSE_DR;
            jtag_scan_pkg::TAP_PAUSE_DR:   tapStep = m ? jtag_scan_pkg::TAP_EXIT2_DR : jtag_scan_pkg::TAP_PAUSE_DR;
            jtag_scan_pkg::TAP_EXIT2_DR:   tapStep = m ? jtag_scan_pkg::TAP_UPDATE_DR : jtag_scan_pkg::TAP_SHIFT_DR;
            jtag_scan_pkg::TAP_UPDATE_DR:  tapStep = m ? jtag_scan_pkg::TAP_SEL_DR   : jtag_scan_pkg::TAP_IDLE;
            jtag_scan_pkg::TAP_SEL_IR:     tapStep = m ? jtag_scan_pkg::TAP_RESET    : jtag_scan_pkg::TAP_CAPTURE_IR;
            jtag_scan_pkg::TAP_CAPTURE_IR: tapStep = m ? jtag_scan_pkg::TAP_EXIT1_IR : jtag_scan_pkg::TAP_SHIFT_IR;
            jtag_scan_pkg::TAP_SHIFT_IR:   tapStep = m ? jtag_scan_pkg::TAP_EXIT1_IR : jtag_scan_pkg::TAP_SHIFT_IR;
            jtag_scan_pkg::TAP_EXIT1_IR:   tapStep = m ? jtag_scan_pkg::TAP_UPDATE_IR : jtag_scan_pkg::TAP_PAUSE_IR;
            jtag_scan_pkg::TAP_PAUSE_IR:   tapStep = m ? jtag_scan_pkg::TAP_EXIT2_IR : jtag_scan_pkg::TAP_PAUSE_IR;
            jtag_scan_pkg::TAP_EXIT2_IR:   tapStep = m ? jtag_scan_pkg::TAP_UPDATE_IR : jtag_scan_pkg::TAP_SHIFT_IR;
            jtag_scan_pkg::TAP_UPDATE_IR:  tapStep = m ? jtag_scan_pkg::TAP_SEL_DR   : jtag_scan_pkg::TAP_IDLE;
            default:                       tapStep = jtag_scan_pkg::TAP_RESET;
        endcase
    endfunction

    // True when the instruction routes the boundary chain between TDI and TDO
    function automatic logic usesChain(input jtag_scan_pkg::instr_t i);
        usesChain = (i == `INSTR_EXTEST) || (i == `INSTR_SAMPLE);
    endfunction

    // ****************************************
    // TAP, instruction and data registers
    // ****************************************
    jtag_scan_pkg::tap_state_e tap_reg, tap_next;
    jtag_scan_pkg::instr_t     ir_reg, ir_next;
    jtag_scan_pkg::instr_t     irShift_reg, irShift_next;
    logic                      bypass_reg, bypass_next;
    logic [CL-1:0]             chain_reg, chain_next;
    logic [2*NUM_OUT-1:0]      latch_reg, latch_next;
    logic                      wake_reg, wake_next;
    logic                      intr_reg, intr_next;
    logic                      tdo_reg, tdo_next;
    logic                      tdoOe_reg, tdoOe_next;
    logic                      pushValid, pushReady, pushBit;
    logic                      popValid, popBit;
    logic                      shifting, extestOn;

    assign extestOn = (ir_reg == `INSTR_EXTEST);
    assign shifting = (tap_reg == jtag_scan_pkg::TAP_SHIFT_DR) || (tap_reg == jtag_scan_pkg::TAP_SHIFT_IR);

    // Next bit due on TDO, queued at a rise that ends in a shift state, shown at the next fall
    always_comb begin
        pushValid = tckRise && ((tap_next == jtag_scan_pkg::TAP_SHIFT_DR) || (tap_next == jtag_scan_pkg::TAP_SHIFT_IR));
        if (tap_next == jtag_scan_pkg::TAP_SHIFT_IR) begin
            pushBit = irShift_next[0];
        end else if (usesChain(ir_reg)) begin
            pushBit = chain_next[0];
        end else begin
            pushBit = bypass_next;
        end
    end

    always_comb begin
        tap_next     = tap_reg;
        ir_next      = ir_reg;
        irShift_next = irShift_reg;
        bypass_next  = bypass_reg;
        chain_next   = chain_reg;
        latch_next   = latch_reg;
        wake_next    = 1'b0;
        intr_next    = 1'b0;
        tdo_next     = tdo_reg;
        tdoOe_next   = tdoOe_reg;
        if (!trstNF) begin
            tap_next = jtag_scan_pkg::TAP_RESET;
            ir_next  = `INSTR_BYPASS;
        end else if (tckRise) begin
            tap_next = tapStep(tap_reg, tmsF);
            case (tap_reg)
                jtag_scan_pkg::TAP_RESET: begin
                    ir_next = `INSTR_BYPASS;
                end
                jtag_scan_pkg::TAP_CAPTURE_IR: begin
                    irShift_next = `IR_CAPTURE_VAL;
                end
                jtag_scan_pkg::TAP_SHIFT_IR: begin
                    irShift_next = {tdiF, irShift_reg[`IR_WIDTH-1:1]};
                end
                jtag_scan_pkg::TAP_UPDATE_IR: begin
                    // Commands are dropped in standby, TAP still walks
                    if (!standbyMode) begin
                        if (irShift_reg == `INSTR_INTERRUPT) begin
                            intr_next = 1'b1;
                            ir_next   = `INSTR_BYPASS;
                        end else begin
                            ir_next = irShift_reg;
                        end
                        wake_next = (irShift_reg == `INSTR_WAKE);
                    end
                end
                jtag_scan_pkg::TAP_CAPTURE_DR: begin
                    bypass_next = 1'b0;
                    if (usesChain(ir_reg)) begin
                        // Snapshot of pin inputs and of the values leaving
                        // towards the pins
                        chain_next = {pinOe, pinOut, inF};
                    end
                end
                jtag_scan_pkg::TAP_SHIFT_DR: begin
                    bypass_next = tdiF;
                    if (usesChain(ir_reg)) begin
                        // Results leave as the next pattern enters
                        chain_next = {tdiF, chain_reg[CL-1:1]};
                    end
                end
                jtag_scan_pkg::TAP_UPDATE_DR: begin
                    if (usesChain(ir_reg)) begin
                        // Only the output data and enable cells reach the latches
                        latch_next = chain_reg[CL-1:NI];
                    end
                end
                default: begin
                    tap_next = tapStep(tap_reg, tmsF);
                end
            endcase
        end else if (tckFall) begin
            tdoOe_next = shifting;
            if (popValid) begin
                tdo_next = popBit;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tap_reg     <= jtag_scan_pkg::TAP_RESET;
            ir_reg      <= `INSTR_BYPASS;
            irShift_reg <= '0;
            bypass_reg  <= 1'b0;
            chain_reg   <= '0;
            latch_reg   <= '0;
            wake_reg    <= 1'b0;
            intr_reg    <= 1'b0;
            tdo_reg     <= 1'b0;
            tdoOe_reg   <= 1'b0;
        end else begin
            tap_reg     <= tap_next;
            ir_reg      <= ir_next;
            irShift_reg <= irShift_next;
            bypass_reg  <= bypass_next;
            chain_reg   <= chain_next;
            latch_reg   <= latch_next;
            wake_reg    <= wake_next;
            intr_reg    <= intr_next;
            tdo_reg     <= tdo_next;
            tdoOe_reg   <= tdoOe_next;
        end
    end

    // ****************************************
    // TDO buffer
    // ****************************************
    // Holds a bit between rising and falling edge; flushed in Test-Logic-Reset
    // so a stale bit never appears on the next shift.
    tdo_fifo #(
        .WIDTH (1),
        .DEPTH (`TDO_FIFO_DEPTH)
    ) u_tdo_fifo (
        .clock    (clock),
        .reset    (reset),
        .flush    (tap_reg == jtag_scan_pkg::TAP_RESET),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushBit),
        .outValid (popValid),
        .outReady (tckFall),
        .outData  (popBit)
    );

    // ****************************************
    // Pin multiplexing
    // ****************************************
    // Inputs always reach the core; outputs follow the core except in
    // external test, where the latches own the pins.
    assign coreIn = pinIn;
    assign pinOut = extestOn ? latch_reg[NUM_OUT-1:0]         : coreOut;
    assign pinOe  = extestOn ? latch_reg[2*NUM_OUT-1:NUM_OUT] : coreOe;

    assign tdo            = tdo_reg;
    assign tdoOe          = tdoOe_reg;
    assign sleepWake      = wake_reg;
    assign debugInterrupt = intr_reg;
    assign activeInstr    = ir_reg;

endmodule

/* File: testbench/jtag_boundary_scan_checker.sv */
`timescale 1ns/1ns
`include "jtag_scan_cfg.svh"

module jtag_boundary_scan_checker #(
    parameter int NUM_IN  = 8,
    parameter int NUM_OUT = 8
) (
    // Clock and reset
    input wire logic               clock,
    input wire logic               reset,
    // Debug port
    input wire logic               tck,
    input wire logic               tms,
    input wire logic               tdi,
    input wire logic               trstN,
    input wire logic               tdo,
    input wire logic               tdoOe,
    // Pins and core
    input wire logic [NUM_IN-1:0]  pinIn,
    input wire logic               crystalInput,
    input wire logic               busClockPin,
    input wire logic [NUM_OUT-1:0] pinOut,
    input wire logic [NUM_OUT-1:0] pinOe,
    input wire logic [NUM_IN-1:0]  coreIn,
    input wire logic [NUM_OUT-1:0] coreOut,
    input wire logic [NUM_OUT-1:0] coreOe,
    // Commands
    input wire logic               standbyMode,
    input wire logic               sleepWake,
    input wire logic               debugInterrupt,
    input wire logic [`IR_WIDTH-1:0] activeInstr
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence trstHeld; !trstN [*8]; endsequence
    sequence wakePulse; sleepWake ##1 !sleepWake; endsequence
    sequence irqPulse; debugInterrupt ##1 !debugInterrupt; endsequence

    AST_CORE_IN: assert property (coreIn == pinIn)
        else $error("core input differs from board pin");
    AST_PINS_NORMAL: assert property (activeInstr != `INSTR_EXTEST |-> pinOut == coreOut && pinOe == coreOe)
        else $error("pins not following core outside external test");
    AST_EXTEST_STEADY: assert property (activeInstr == `INSTR_EXTEST && tdoOe |=> $stable(pinOut) && $stable(pinOe))
        else $error("pins moved during a shift in external test");
    AST_WAKE: assert property ($rose(sleepWake) |-> wakePulse ##0 activeInstr == `INSTR_WAKE)
        else $error("wake pulse malformed");
    AST_IRQ: assert property ($rose(debugInterrupt) |-> irqPulse ##[0:8] activeInstr == `INSTR_BYPASS)
        else $error("interrupt command did not revert to bypass");
    AST_TRST: assert property (trstHeld |-> activeInstr == `INSTR_BYPASS && !tdoOe)
        else $error("test reset did not clear the port");
    AST_TDO_FALL: assert property (($changed(tdo) || $changed(tdoOe)) && trstN |-> !tck && !$past(tck, 2))
        else $error("data out moved away from a falling link edge");
    AST_INSTR_HOLD: assert property ($changed(activeInstr) && trstN && $past(activeInstr) != `INSTR_INTERRUPT |-> tck)
        else $error("instruction changed without an update");
    AST_STANDBY: assert property (standbyMode && $past(standbyMode, 8) && trstN |-> $stable(activeInstr))
        else $error("instruction loaded in standby");
endmodule

bind jtag_boundary_scan jtag_boundary_scan_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) chk (
    .clock(clock), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo),
    .tdoOe(tdoOe), .pinIn(pinIn), .crystalInput(crystalInput), .busClockPin(busClockPin),
    .pinOut(pinOut), .pinOe(pinOe), .coreIn(coreIn), .coreOut(coreOut), .coreOe(coreOe),
    .standbyMode(standbyMode), .sleepWake(sleepWake), .debugInterrupt(debugInterrupt),
    .activeInstr(activeInstr));

/* File: testbench/jtag_tester_model.sv */
`timescale 1ns/1ns

module jtag_tester_model (
    // Clock
    input wire logic clock,
    // Link
    output logic     tck,
    output logic     tms,
    output logic     tdi,
    output logic     trstN,
    input wire logic tdo,
    input wire logic tdoOe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trstN = 1'b1;
    end

    // ****
    // Link cycles
    // ****
    // Link clock only moves inside these tasks; idle it stays low
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (8) @(posedge clock);
        #1;
        // A released line reads as the inverse, so a late enable is caught
        q = tdoOe ? tdo : ~tdo;
        tck = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        tck = 1'b0;
    endtask

    // From Idle through one IR or DR scan back to Idle, bits lowest first
    task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir) begin
            step(1'b1, ~tdi, q);
        end
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask

    task automatic pulse_trst;
        logic q;
        @(posedge clock);
        #1;
        trstN = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        trstN = 1'b1;
        repeat (6) @(posedge clock);
        step(1'b0, ~tdi, q);
    endtask
endmodule

/* File: testbench/test_jtag_boundary_scan.sv */
`timescale 1ns/1ns

module test_jtag_boundary_scan;
    localparam int NI = 4;
    localparam int NO = 4;
    logic          clock, reset, tck, tms, tdi, trstN, tdo, tdoOe;
    logic          crystalInput, busClockPin, standbyMode, sleepWake, debugInterrupt;
    logic [NI-1:0] pinIn, coreIn;
    logic [NO-1:0] pinOut, pinOe, coreOut, coreOe;
    logic [3:0]    activeInstr;
    logic [31:0]   got;
    int            bad_count, checks_done, wakeCount, irqCount;

    jtag_boundary_scan #(.NUM_IN(NI), .NUM_OUT(NO)) uut (.clock(clock), .reset(reset), .tck(tck),
        .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .pinIn(pinIn),
        .crystalInput(crystalInput), .busClockPin(busClockPin), .pinOut(pinOut), .pinOe(pinOe),
        .coreIn(coreIn), .coreOut(coreOut), .coreOe(coreOe), .standbyMode(standbyMode),
        .sleepWake(sleepWake), .debugInterrupt(debugInterrupt), .activeInstr(activeInstr));
    jtag_tester_model tester (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo),
        .tdoOe(tdoOe));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Bus clock keeps running at 2 MHz; its cell is masked since its phase is free
    always begin
        repeat (25) @(posedge clock);
        #1 busClockPin = ~busClockPin;
    end
    always @(posedge clock) begin
        if (sleepWake === 1'b1) wakeCount++;
        if (debugInterrupt === 1'b1) irqCount++;
    end

    // ****
    // Helpers
    // ****
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic load(input logic [3:0] code);
        tester.scan(1'b1, {28'h0, code}, 4, got);
        chk("ir capture", 32'h1, got);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_bypass;
        logic [3:0] codes [2] = '{4'hF, 4'h7};
        chk("reset instr", 4'hF, activeInstr);
        foreach (codes[k]) begin
            load(codes[k]);
            tester.scan(1'b0, 32'h0000_00A5, 8, got);
            chk("bypass out", 32'h0000_004A, got);
            chk("bypass pins", coreOut, pinOut);
        end
    endtask
    task automatic t_wake;
        int w0;
        w0 = wakeCount;
        load(4'h1);
        chk("wake count", w0 + 1, wakeCount);
        repeat (40) @(posedge clock);
        chk("held instr", 4'h1, activeInstr);
    endtask
    task automatic t_sample;
        load(4'h4);
        @(posedge clock);
        #1;
        pinIn = 4'h9;
        crystalInput = 1'b1;
        coreOut = 4'h6;
        coreOe = 4'hC;
        @(posedge clock);
        chk("core in", 4'h9, coreIn);
        tester.scan(1'b0, 32'h0000_5A03, 16, got);
        chk("sample", {16'h0, 2'b11, 4'hC, 4'h6, 1'b0, 1'b1, 4'h9}, got & ~32'h20);
        chk("pins after preload", 4'h6, pinOut);
    endtask
    task automatic t_extest;
        load(4'h0);
        chk("latched data", 4'hA, pinOut);
        chk("latched enable", 4'h5, pinOe);
        @(posedge clock);
        #1;
        pinIn = 4'h3;
        tester.scan(1'b0, 32'h0000_38C0, 14, got);
        chk("extest capture", {18'h0, 4'h5, 4'hA, 1'b0, 1'b1, 4'h3}, got & ~32'h20);
        chk("new data", 4'h3, pinOut);
        chk("new enable", 4'hE, pinOe);
    endtask
    task automatic t_irq_standby;
        int w0;
        int i0;
        i0 = irqCount;
        load(4'h5);
        chk("irq count", i0 + 1, irqCount);
        chk("revert", 4'hF, activeInstr);
        load(4'h4);
        @(posedge clock);
        #1;
        standbyMode = 1'b1;
        w0 = wakeCount;
        load(4'h1);
        chk("standby instr", 4'h4, activeInstr);
        chk("standby wake", w0, wakeCount);
        @(posedge clock);
        #1;
        standbyMode = 1'b0;
        tester.pulse_trst;
        chk("trst instr", 4'hF, activeInstr);
    endtask

    initial begin
        reset = 1'b1;
        pinIn = '0;
        crystalInput = 1'b0;
        busClockPin = 1'b0;
        coreOut = '0;
        coreOe = '0;
        standbyMode = 1'b0;
        repeat (12) @(posedge clock);
        #1 reset = 1'b0;
        repeat (6) @(posedge clock);
        // Scans start from Run-Test/Idle, so leave Test-Logic-Reset first
        tester.step(1'b0, 1'b0, got[0]);
        t_bypass;
        t_wake;
        t_sample;
        t_extest;
        t_irq_standby;
        wrap_up;
    end
    initial begin
        #200_000;
        bad_count++;
        wrap_up;
    end
endmodule
